// File: shared/mmf_pkg.sv
// Constants for the motion mode front-end: mode codes, register map,
// statusword bit positions, reset values and timing counts.
// Assumes a 125 MHz system clock.
package mmf_pkg;

  // ------------------------------------------------------------------
  // Clock and time base
  // ------------------------------------------------------------------
  localparam int CLK_HZ          = 125_000_000;
  localparam int BASE_TICK_MS    = 1;
  localparam int BASE_TICK_CYC   = CLK_HZ / 1000 * BASE_TICK_MS;
  localparam logic [7:0] TIME_INDEX_MS = 8'hFD;

  // ------------------------------------------------------------------
  // Operating modes
  // ------------------------------------------------------------------
  localparam logic [7:0] MODE_CST    = 8'h0A;
  localparam logic [7:0] MODE_CLKDIR = 8'hFF;
  localparam logic [7:0] MODE_SETUP  = 8'hFE;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_MODE     = 8'h00;
  localparam logic [7:0] REG_CTRL     = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_TGT_TRQ  = 8'h0C;
  localparam logic [7:0] REG_MAX_TRQ  = 8'h10;
  localparam logic [7:0] REG_MAX_CUR  = 8'h14;
  localparam logic [7:0] REG_TRQ_OFS  = 8'h18;
  localparam logic [7:0] REG_IP_PER   = 8'h1C;
  localparam logic [7:0] REG_IP_IDX   = 8'h20;
  localparam logic [7:0] REG_STEP_NUM = 8'h24;
  localparam logic [7:0] REG_STEP_DEN = 8'h28;
  localparam logic [7:0] REG_SUBTYPE  = 8'h2C;
  localparam logic [7:0] REG_FE_WIN   = 8'h30;
  localparam logic [7:0] REG_FE_TMO   = 8'h34;
  localparam logic [7:0] REG_DEMAND   = 8'h38;
  localparam logic [7:0] REG_TRQ_DMD  = 8'h3C;
  localparam logic [7:0] REG_ACT_POS  = 8'h40;

  // ------------------------------------------------------------------
  // Bit positions
  // ------------------------------------------------------------------
  localparam int CW_START_BIT  = 4;
  localparam int SW_SYNC_BIT   = 8;
  localparam int SW_INDEX_BIT  = 10;
  localparam int SW_FOLLOW_BIT = 12;
  localparam int SW_FERR_BIT   = 13;
  localparam int CFG_CLOSED_BIT = 0;

  // ------------------------------------------------------------------
  // Reset values, setup time and full steps per pole pair
  // ------------------------------------------------------------------
  localparam logic [15:0] RST_STEP_NUM = 16'h0080;
  localparam logic [15:0] RST_STEP_DEN = 16'h0001;
  localparam logic [15:0] RST_IP_PER   = 16'h0001;
  localparam logic [15:0] RST_MAX_TRQ  = 16'h03E8;
  localparam logic [15:0] RST_MAX_CUR  = 16'h03E8;
  localparam logic [15:0] RST_FE_TMO   = 16'h0064;
  localparam logic [31:0] RST_FE_WIN   = 32'h0000_0100;
  localparam int SETUP_TIME_MS = 16;
  localparam int FULL_STEPS_PER_PP = 4;

endpackage : mmf_pkg

// File: logic/mmf_frontend.sv
// Mode front-end: cyclic torque, clock-direction and auto setup modes.
// Assumes a register master on clk_i and step pins from another domain.
//
// Behaviour
// - Mode 10 follows torque setpoint, no ramps
// - Torque mode: status bit 8 shows sync
// - Torque mode: status bit 12 shows target used
// - Torque clamped to min of max torque/current
// - Cycle equals period times ten^index, 1 ms
// - Torque offset added before applying setpoint
// - Torque mode: controlword bits have no meaning
// - Mode FFh selects clock-direction mode
// - One step per clock pulse, given direction
// - Pulses buffered, demand updated once per cycle
// - Step width is numerator over denominator
// - Brushless motor: four full steps per pole pair
// - Closed loop: bit 13 on lasting following error
// - Subtype 0: clock plus direction inputs
// - Subtype 1: input used gives direction
// - Mode FEh selects auto setup
// - Setup starts on controlword bit 4 rise
// - Setup: bit 10 shows index found
// - Setup: bit 12 set when concluded
`timescale 1ns/1ns
module mmf_frontend
  import mmf_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // Step pins
  input  wire logic        step_a_i,
  input  wire logic        step_b_i,
  // Motor side status
  input  wire logic        index_seen_i,
  input  wire logic        fb_sync_i,
  // Outputs
  output logic [15:0]      statusword_o,
  output logic [15:0]      torque_demand_o,
  output logic [31:0]      demand_pos_o,
  output logic             cycle_tick_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  mode_r;
  logic [15:0] ctrl_r;
  logic [15:0] tgt_trq_r, max_trq_r, max_cur_r, trq_ofs_r;
  logic [15:0] ip_per_r, step_num_r, step_den_r, fe_tmo_r;
  logic [7:0]  ip_idx_r;
  logic [7:0]  subtype_r;
  logic [31:0] fe_win_r, act_pos_r;
  logic        closed_r;
  logic        tgt_fresh_r;

  function automatic logic hit(input logic [7:0] a);
    hit = wr_i && (addr_i == a);
  endfunction : hit

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_r     <= 8'h00;
      ctrl_r     <= 16'h0000;
      tgt_trq_r  <= 16'h0000;
      max_trq_r  <= RST_MAX_TRQ;
      max_cur_r  <= RST_MAX_CUR;
      trq_ofs_r  <= 16'h0000;
      ip_per_r   <= RST_IP_PER;
      ip_idx_r   <= TIME_INDEX_MS;
      step_num_r <= RST_STEP_NUM;
      step_den_r <= RST_STEP_DEN;
      subtype_r  <= 8'h00;
      fe_win_r   <= RST_FE_WIN;
      fe_tmo_r   <= RST_FE_TMO;
      act_pos_r  <= 32'h0000_0000;
      closed_r   <= 1'b0;
    end else begin
      if (hit(REG_MODE))     mode_r     <= wdata_i[7:0];
      if (hit(REG_CTRL))     ctrl_r     <= wdata_i[15:0];
      if (hit(REG_TGT_TRQ))  tgt_trq_r  <= wdata_i[15:0];
      if (hit(REG_MAX_TRQ))  max_trq_r  <= wdata_i[15:0];
      if (hit(REG_MAX_CUR))  max_cur_r  <= wdata_i[15:0];
      if (hit(REG_TRQ_OFS))  trq_ofs_r  <= wdata_i[15:0];
      if (hit(REG_IP_PER))   ip_per_r   <= wdata_i[15:0];
      // Only the 1 ms base is accepted
      if (hit(REG_IP_IDX) && wdata_i[7:0] == TIME_INDEX_MS)
        ip_idx_r <= wdata_i[7:0];
      if (hit(REG_STEP_NUM)) step_num_r <= wdata_i[15:0];
      // A zero denominator would make the step width undefined
      if (hit(REG_STEP_DEN) && wdata_i[15:0] != 16'h0000)
        step_den_r <= wdata_i[15:0];
      if (hit(REG_SUBTYPE))  subtype_r  <= wdata_i[7:0];
      if (hit(REG_FE_WIN))   fe_win_r   <= wdata_i;
      if (hit(REG_FE_TMO))   fe_tmo_r   <= wdata_i[15:0];
      if (hit(REG_ACT_POS))  act_pos_r  <= wdata_i;
      if (hit(REG_IP_IDX))   closed_r   <= wdata_i[8 + CFG_CLOSED_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Interpolation cycle tick
  // ----------------------------------------------------------------
  logic [16:0] ms_cnt_r;
  logic [15:0] per_cnt_r;
  logic        ms_tick;
  logic        cyc_tick;
  assign ms_tick  = (ms_cnt_r == 17'(BASE_TICK_CYC - 1));
  assign cyc_tick = ms_tick && (per_cnt_r + 16'h0001 >= ip_per_r);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ms_cnt_r  <= 17'h00000;
      per_cnt_r <= 16'h0000;
    end else begin
      ms_cnt_r <= ms_tick ? 17'h00000 : ms_cnt_r + 17'h00001;
      if (cyc_tick)
        per_cnt_r <= 16'h0000;
      else if (ms_tick)
        per_cnt_r <= per_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) cycle_tick_o <= 1'b0;
    else            cycle_tick_o <= cyc_tick;
  end

  // ----------------------------------------------------------------
  // Cyclic synchronous torque
  // ----------------------------------------------------------------
  logic        in_cst;
  logic [15:0] trq_lim;
  logic signed [17:0] trq_sum;
  logic signed [17:0] trq_lim_s;
  logic [15:0] trq_nxt;
  assign in_cst    = (mode_r == MODE_CST);
  assign trq_lim   = (max_trq_r < max_cur_r) ? max_trq_r : max_cur_r;
  assign trq_lim_s = $signed({2'b00, trq_lim});
  assign trq_sum   = 18'($signed(tgt_trq_r)) + 18'($signed(trq_ofs_r));

  always_comb begin
    if (trq_sum > trq_lim_s)
      trq_nxt = trq_lim;
    else if (trq_sum < -trq_lim_s)
      trq_nxt = 16'(-trq_lim_s);
    else
      trq_nxt = trq_sum[15:0];
  end

  // Target taken as-is each write, no ramp is computed
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      torque_demand_o <= 16'h0000;
      tgt_fresh_r     <= 1'b0;
    end else begin
      torque_demand_o <= in_cst ? trq_nxt : 16'h0000;
      // Write seen this cycle; set wins over the cycle clear
      if (hit(REG_TGT_TRQ))
        tgt_fresh_r <= 1'b1;
      else if (cyc_tick)
        tgt_fresh_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Step pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] a_sync_r, b_sync_r;
  logic       a_lvl_r, b_lvl_r;
  logic       a_rise, b_rise;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      a_sync_r <= 3'h0;
      b_sync_r <= 3'h0;
      a_lvl_r  <= 1'b0;
      b_lvl_r  <= 1'b0;
    end else begin
      a_sync_r <= {a_sync_r[1:0], step_a_i};
      b_sync_r <= {b_sync_r[1:0], step_b_i};
      if (a_sync_r[1] == a_sync_r[2]) a_lvl_r <= a_sync_r[2];
      if (b_sync_r[1] == b_sync_r[2]) b_lvl_r <= b_sync_r[2];
    end
  end
  assign a_rise = a_sync_r[1] && a_sync_r[2] && !a_lvl_r;
  assign b_rise = b_sync_r[1] && b_sync_r[2] && !b_lvl_r;

  // ----------------------------------------------------------------
  // Clock-direction accumulation
  // ----------------------------------------------------------------
  logic        in_cd;
  logic        step_up, step_dn;
  logic signed [31:0] pulse_acc_r;
  logic signed [47:0] scaled;
  assign in_cd = (mode_r == MODE_CLKDIR);

  // 200 ns pulses at 8 ns clock leave margin for the filter
  always_comb begin
    step_up = 1'b0;
    step_dn = 1'b0;
    if (in_cd) begin
      if (subtype_r == 8'h01) begin
        step_up = a_rise;
        step_dn = b_rise;
      end else begin
        step_up = a_rise && !b_lvl_r;
        step_dn = a_rise &&  b_lvl_r;
      end
    end
  end

  // Demand is in 1/512 full step; motor maps 4 steps per pole pair
  assign scaled = 48'(pulse_acc_r) * 48'($signed({1'b0, step_num_r}))
                / 48'($signed({1'b0, step_den_r}));

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pulse_acc_r  <= 32'sh0000_0000;
      demand_pos_o <= 32'h0000_0000;
    end else begin
      if (cyc_tick) begin
        demand_pos_o <= demand_pos_o + scaled[31:0];
        pulse_acc_r  <= 32'(step_up) - 32'(step_dn);
      end else begin
        pulse_acc_r <= pulse_acc_r + 32'(step_up) - 32'(step_dn);
      end
    end
  end

  // ----------------------------------------------------------------
  // Following error in closed loop
  // ----------------------------------------------------------------
  logic [31:0] ferr;
  logic        outside;
  logic [15:0] fe_cnt_r;
  logic        ferr_r;
  assign ferr    = demand_pos_o - act_pos_r;
  assign outside = ($signed(ferr) > $signed(fe_win_r))
                || ($signed(ferr) < -$signed(fe_win_r));

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fe_cnt_r <= 16'h0000;
      ferr_r   <= 1'b0;
    end else if (!(in_cd && closed_r && outside)) begin
      fe_cnt_r <= 16'h0000;
      ferr_r   <= 1'b0;
    end else if (ms_tick) begin
      if (fe_cnt_r >= fe_tmo_r)
        ferr_r <= 1'b1;
      else
        fe_cnt_r <= fe_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Auto setup
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SU_IDLE, SU_RUN, SU_DONE} mmf_su_t;
  mmf_su_t     su_r;
  logic        in_su;
  logic        start_prev_r;
  logic        indexed_r;
  logic [4:0]  su_cnt_r;
  assign in_su = (mode_r == MODE_SETUP);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) start_prev_r <= 1'b0;
    else            start_prev_r <= ctrl_r[CW_START_BIT];
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      su_r      <= SU_IDLE;
      su_cnt_r  <= 5'h00;
      indexed_r <= 1'b0;
    end else if (!in_su) begin
      su_r <= SU_IDLE;
    end else begin
      unique case (su_r)
        SU_IDLE: begin
          if (ctrl_r[CW_START_BIT] && !start_prev_r) begin
            su_r      <= SU_RUN;
            su_cnt_r  <= 5'h00;
            indexed_r <= 1'b0;
          end
        end
        SU_RUN: begin
          if (index_seen_i) indexed_r <= 1'b1;
          if (ms_tick) su_cnt_r <= su_cnt_r + 5'h01;
          if (su_cnt_r == 5'(SETUP_TIME_MS)) su_r <= SU_DONE;
        end
        SU_DONE: begin
          if (ctrl_r[CW_START_BIT] && !start_prev_r) begin
            su_r      <= SU_RUN;
            su_cnt_r  <= 5'h00;
            indexed_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Statusword and read port
  // ----------------------------------------------------------------
  logic [15:0] sw_nxt;
  always_comb begin
    sw_nxt = 16'h0000;
    // Controlword is not decoded at all in torque mode
    if (in_cst) begin
      sw_nxt[SW_SYNC_BIT]   = fb_sync_i;
      sw_nxt[SW_FOLLOW_BIT] = tgt_fresh_r || hit(REG_TGT_TRQ);
    end
    if (in_cd)
      sw_nxt[SW_FERR_BIT] = ferr_r;
    if (in_su) begin
      sw_nxt[SW_INDEX_BIT]  = indexed_r;
      sw_nxt[SW_FOLLOW_BIT] = (su_r == SU_DONE);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) statusword_o <= 16'h0000;
    else            statusword_o <= sw_nxt;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      unique case (addr_i)
        REG_MODE:     rdata_o <= {24'h000000, mode_r};
        REG_CTRL:     rdata_o <= {16'h0000, ctrl_r};
        REG_STATUS:   rdata_o <= {16'h0000, statusword_o};
        REG_TGT_TRQ:  rdata_o <= {16'h0000, tgt_trq_r};
        REG_MAX_TRQ:  rdata_o <= {16'h0000, max_trq_r};
        REG_MAX_CUR:  rdata_o <= {16'h0000, max_cur_r};
        REG_TRQ_OFS:  rdata_o <= {16'h0000, trq_ofs_r};
        REG_IP_PER:   rdata_o <= {16'h0000, ip_per_r};
        REG_IP_IDX:   rdata_o <= {23'h000000, closed_r, ip_idx_r};
        REG_STEP_NUM: rdata_o <= {16'h0000, step_num_r};
        REG_STEP_DEN: rdata_o <= {16'h0000, step_den_r};
        REG_SUBTYPE:  rdata_o <= {24'h000000, subtype_r};
        REG_FE_WIN:   rdata_o <= fe_win_r;
        REG_FE_TMO:   rdata_o <= {16'h0000, fe_tmo_r};
        REG_DEMAND:   rdata_o <= demand_pos_o;
        REG_TRQ_DMD:  rdata_o <= {16'h0000, torque_demand_o};
        REG_ACT_POS:  rdata_o <= act_pos_r;
        default:      rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_torque_limit: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    in_cst |=> ($signed(torque_demand_o) <= $signed({1'b0, $past(trq_lim)})))
    else $error("torque demand above limit");
  chk_idle_torque: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !in_cst |=> torque_demand_o == 16'h0000)
    else $error("torque outside torque mode");
  chk_sync_bit: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    in_cst |=> statusword_o[SW_SYNC_BIT] == $past(fb_sync_i))
    else $error("sync bit wrong");
  chk_follow_bit: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (in_cst && wr_i && addr_i == REG_TGT_TRQ) |=> statusword_o[SW_FOLLOW_BIT])
    else $error("follow bit missing");
  chk_demand_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !cyc_tick |=> $stable(demand_pos_o))
    else $error("demand moved mid cycle");
  chk_no_pulse: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !in_cd |-> !step_up && !step_dn)
    else $error("pulse counted outside mode");
  chk_setup_start: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (su_r == SU_IDLE && !(ctrl_r[CW_START_BIT] && !start_prev_r))
    |=> su_r != SU_RUN)
    else $error("setup ran without edge");
  chk_aligned_bit: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (in_su && su_r == SU_DONE) |=> statusword_o[SW_FOLLOW_BIT])
    else $error("aligned bit missing");
  chk_ferr_mode: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !(in_cd && closed_r) |=> ##1 !statusword_o[SW_FERR_BIT])
    else $error("following error out of mode");

endmodule : mmf_frontend

// File: verification/mmf_step_src.sv
// Step pulse source standing in for the higher-level positioning controller.
// Assumes the bench calls pulse() from one process and sets dual_i first.
`timescale 1ns/1ns
module mmf_step_src (
  // Clock and subtype
  input  wire logic clk_i,
  input  wire logic dual_i,
  // Step pins
  output logic      step_a_o,
  output logic      step_b_o
);
  // ------------------------------------------------------------------
  // Pulse generation
  // ------------------------------------------------------------------
  // 35 us at 8 ns a cycle; the full gap is taken on each direction change, never shortened
  localparam int DIR_GAP = 4375;
  logic last_neg = 1'b0;

  initial begin
    step_a_o = 1'b0;
    step_b_o = 1'b0;
  end

  task automatic pulse(input logic neg, input int hi);
    if (neg !== last_neg) begin
      @(posedge clk_i);
      if (!dual_i) step_b_o <= neg;
      repeat (DIR_GAP) @(posedge clk_i);
    end
    last_neg = neg;
    @(posedge clk_i);
    if (dual_i && neg) step_b_o <= 1'b1;
    else step_a_o <= 1'b1;
    repeat (hi) @(posedge clk_i);
    step_a_o <= 1'b0;
    if (dual_i) step_b_o <= 1'b0;
    repeat (hi) @(posedge clk_i);
  endtask : pulse
endmodule : mmf_step_src

// File: verification/tb_mmf_frontend.sv
// Self-checking bench for the motion mode front-end.
// Assumes the 1 ms tick cannot be shortened, so the run spans one tick.
`timescale 1ns/1ns
module tb_mmf_frontend
  import mmf_pkg::*;
;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        index_seen_i = 1'b0;
  logic        fb_sync_i = 1'b0;
  logic        dual = 1'b0;
  logic        step_a_i, step_b_i, cycle_tick_o, tick_q;
  logic [31:0] rdata_o, demand_pos_o, dmd_q;
  logic [15:0] statusword_o, torque_demand_o;
  logic        mon_on = 1'b0;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cyc_n = 0;

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_n <= cyc_n + 1;

  mmf_frontend dut_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .step_a_i(step_a_i), .step_b_i(step_b_i),
    .index_seen_i(index_seen_i), .fb_sync_i(fb_sync_i),
    .statusword_o(statusword_o), .torque_demand_o(torque_demand_o),
    .demand_pos_o(demand_pos_o), .cycle_tick_o(cycle_tick_o)
  );

  mmf_step_src src_u (
    .clk_i(clk_i), .dual_i(dual), .step_a_o(step_a_i), .step_b_o(step_b_i)
  );

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      $display("[FAIL] %0t %s", $time, msg);
      num_errors++;
    end
  endtask : chk

  task automatic close_out();
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk(rdata_o === e, "register read mismatch");
  endtask : rd_chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_cyc

  // Bounded: a tick that never comes ends the run
  task automatic wait_tick(output int at);
    int i;
    for (i = 0; i < 130000; i++) begin
      @(posedge clk_i);
      if (cycle_tick_o === 1'b1) break;
    end
    at = cyc_n;
    if (i >= 130000) begin
      chk(1'b0, "cycle tick missing");
      close_out();
    end
  endtask : wait_tick

  function automatic logic [15:0] exp_trq(int t, int o, int mt, int mc);
    int lim;
    int s;
    lim = (mt < mc) ? mt : mc;
    s = t + o;
    if (s > lim) s = lim;
    if (s < -lim) s = -lim;
    return s[15:0];
  endfunction : exp_trq

  // Demand may only move right at a cycle tick
  always @(posedge clk_i) begin
    dmd_q  <= demand_pos_o;
    tick_q <= cycle_tick_o;
    if (mon_on && demand_pos_o !== dmd_q) begin
      chk(cycle_tick_o === 1'b1 || tick_q === 1'b1, "demand off tick");
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    logic [7:0]  ra [8];
    logic [31:0] rv [8];
    logic [15:0] tq;
    logic [31:0] d0;
    logic        neg;
    int t, o, mt, mc, net, a0, a1;
    ra = '{REG_MAX_TRQ, REG_MAX_CUR, REG_STEP_NUM, REG_STEP_DEN,
           REG_IP_PER, REG_IP_IDX, REG_SUBTYPE, 8'hFC};
    rv = '{{16'h0000, RST_MAX_TRQ}, {16'h0000, RST_MAX_CUR},
           {16'h0000, RST_STEP_NUM}, {16'h0000, RST_STEP_DEN},
           {16'h0000, RST_IP_PER}, {24'h00_0000, TIME_INDEX_MS},
           32'h0000_0000, 32'h0000_0000};
    void'($urandom(86410));
    repeat (11) @(posedge clk_i);
    chk(statusword_o === 16'h0000 && demand_pos_o === 32'h0000_0000,
        "outputs not cleared in reset");
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    a1 = cyc_n;
    wait_cyc(2);
    mon_on = 1'b1;
    for (int i = 0; i < 8; i++) rd_chk(ra[i], rv[i]);
    wr_reg(REG_IP_IDX, 32'h0000_0001);
    rd_chk(REG_IP_IDX, {24'h00_0000, TIME_INDEX_MS});
    wr_reg(REG_STEP_DEN, 32'h0000_0000);
    rd_chk(REG_STEP_DEN, {16'h0000, RST_STEP_DEN});
    // Cyclic torque: random limits, setpoints and offsets
    wr_reg(REG_MODE, {24'h00_0000, MODE_CST});
    wait_cyc(2);
    chk(statusword_o[SW_FOLLOW_BIT] === 1'b0, "follow bit early");
    for (int k = 0; k < 12; k++) begin
      mt = 1 + int'($urandom % 2000);
      mc = 1 + int'($urandom % 2000);
      t = int'($urandom % 6001) - 3000;
      o = int'($urandom % 601) - 300;
      if (k == 0) t = -(mt + mc);
      fb_sync_i <= k[0];
      wr_reg(REG_MAX_TRQ, 32'(mt));
      wr_reg(REG_MAX_CUR, 32'(mc));
      wr_reg(REG_TRQ_OFS, 32'(o));
      wr_reg(REG_TGT_TRQ, 32'(t));
      wait_cyc(4);
      tq = exp_trq(t, o, mt, mc);
      chk(torque_demand_o === tq, "torque demand wrong");
      chk(statusword_o[SW_SYNC_BIT] === k[0], "sync bit wrong");
      chk(statusword_o[SW_FOLLOW_BIT] === 1'b1, "follow bit low");
      wr_reg(REG_CTRL, $urandom);
      wait_cyc(4);
      chk(torque_demand_o === tq, "control word moved torque");
    end
    // Pulses outside clock-direction mode must not count
    for (int k = 0; k < 3; k++) src_u.pulse(1'b0, 5);
    wr_reg(REG_MODE, {24'h00_0000, MODE_CLKDIR});
    wr_reg(REG_STEP_NUM, 32'd512);
    wr_reg(REG_STEP_DEN, 32'd2);
    wait_cyc(2);
    d0 = demand_pos_o;
    net = 0;
    for (int s = 0; s < 2; s++) begin
      wr_reg(REG_SUBTYPE, 32'(s));
      dual <= s[0];
      for (int j = 0; j < 6; j++) begin
        neg = (j == 5) ? 1'b0 : 1'($urandom % 2);
        src_u.pulse(neg, 4 + int'($urandom % 6));
        net += neg ? -1 : 1;
      end
    end
    // Closed loop with actual far off and zero timeout: error at next tick
    wr_reg(REG_ACT_POS, 32'h4000_0000);
    wr_reg(REG_FE_TMO, 32'h0000_0000);
    wr_reg(REG_IP_IDX, {23'h00_0000, 1'b1, TIME_INDEX_MS});
    wait_cyc(4);
    chk(statusword_o[SW_FERR_BIT] === 1'b0, "error before timeout");
    wait_tick(a0);
    wait_cyc(2);
    chk(demand_pos_o === d0 + 32'(net * 256), "demand position wrong");
    chk(statusword_o[SW_FERR_BIT] === 1'b1, "following error missing");
    // Tick output is registered, so it is seen one edge after the period
    chk(a0 - a1 === BASE_TICK_CYC + 1, "cycle period wrong");
    wr_reg(REG_IP_IDX, {24'h00_0000, TIME_INDEX_MS});
    wait_cyc(3);
    chk(statusword_o[SW_FERR_BIT] === 1'b0, "error not cleared");
    chk(torque_demand_o === 16'h0000, "torque outside torque mode");
    // Auto setup: start only on a rising start bit
    wr_reg(REG_MODE, {24'h00_0000, MODE_SETUP});
    wr_reg(REG_CTRL, 32'h0000_0000);
    index_seen_i <= 1'b1;
    wait_cyc(4);
    chk(statusword_o[SW_INDEX_BIT] === 1'b0, "indexed before start");
    wr_reg(REG_CTRL, 32'h0000_0010);
    wait_cyc(4);
    chk(statusword_o[SW_INDEX_BIT] === 1'b1, "index not flagged");
    chk(statusword_o[SW_FOLLOW_BIT] === 1'b0, "aligned too early");
    close_out();
  end
endmodule : tb_mmf_frontend
